// ---- hdl/srx_pkg.sv ----
// Constants shared by the serial receive path control block.
// Assumes a single 100 MHz reference clock and an 8-bit register address.
package srx_pkg;
  // Clock rate
  localparam int CLK_PERIOD_NS = 10;
  // Loss qualification time, least time, rounded up to whole cycles
  localparam int LOSS_TIME_NS = 2300;
  localparam int LOSS_CYCLES = (LOSS_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Acquisition time, longest time, rounded down
  localparam int LOCK_TIME_MS = 10;
  localparam int LOCK_CYCLES = (LOCK_TIME_MS * 1000000) / CLK_PERIOD_NS;
  // Bits per parallel word
  localparam int DEMUX_WIDTH = 16;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATE = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_PARALLEL = 8'h10;
  // Control field positions, all active low
  localparam int CB_SRC_SEL_N = 0;
  localparam int CB_CLK_EN_N = 1;
  localparam int CB_DATA_EN_N = 2;
  localparam int CB_DATA_SIL_N = 3;
  localparam int CB_REF_N = 4;
  localparam int CB_HOLD_N = 5;
  localparam int CB_PAR_SIL_N = 6;
  localparam int CTRL_W = 7;
  // Pull-up behaviour: every control reads high after reset
  localparam logic [6:0] CTRL_RST = 7'h7F;
  // State and interrupt field positions
  localparam int SB_ALOSS = 0;
  localparam int SB_TLOSS = 1;
  localparam int SB_LOCK = 2;
  localparam int SB_UNLOCK = 3;
  localparam int STAT_W = 4;
  localparam logic [3:0] STAT_RST = 4'h0;
  // Oscillator frequency code
  localparam int OSC_W = 8;
  localparam logic [7:0] OSC_MIN = 8'h00;
  localparam logic [7:0] OSC_NOMINAL = 8'h80;
  localparam logic [7:0] OSC_MAX = 8'hFF;
endpackage

// ---- hdl/srx_loss_if.sv ----
// Carrier between the top module and a loss qualification filter.
// Assumes the user side drives raw and reads qual on the same clock.
`timescale 1ns/10ps
interface srx_loss_if;
  logic raw;
  logic qual;
  modport filt (input raw, output qual);
  modport user (output raw, input qual);
endinterface

// ---- hdl/srx_loss_filter.sv ----
// Qualifies a raw loss condition that must persist for a least time.
// Assumes raw is synchronous to i_ref_clk.
`timescale 1ns/10ps
module srx_loss_filter #(
  parameter int HOLD_CYCLES = srx_pkg::LOSS_CYCLES,
  parameter int CW = 8
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Raw condition in, qualified flag out
  srx_loss_if.filt lif
);
  localparam logic [CW-1:0] LAST = CW'(HOLD_CYCLES - 1);
  logic [CW-1:0] cnt_r;
  logic qual_r;

  // Count consecutive cycles of the raw condition; any gap restarts it
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      qual_r <= 1'b0;
    end else if (!lif.raw) begin
      cnt_r <= '0;
      qual_r <= 1'b0;
    end else if (cnt_r == LAST) begin
      qual_r <= 1'b1;
    end else begin
      cnt_r <= cnt_r + CW'(1);
    end
  end
  assign lif.qual = qual_r;

  a_loss_sustain: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(qual_r) |-> $past(lif.raw) && cnt_r == LAST)
    else $error("loss flag rose before the hold time");
  a_loss_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !lif.raw |=> !qual_r)
    else $error("loss flag held without raw condition");
endmodule

// ---- hdl/srx_clk_div.sv ----
// Divides the recovered bit clock down to the parallel word clock.
// Assumes one recovered bit per cycle of i_ref_clk.
`timescale 1ns/10ps
module srx_clk_div #(
  parameter int RATIO = srx_pkg::DEMUX_WIDTH,
  parameter int CW = 4
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Divided clock and word boundary
  output logic o_slow_clk,
  output logic o_wrap
);
  localparam logic [CW-1:0] LAST = CW'(RATIO - 1);
  localparam logic [CW-1:0] HALF = CW'(RATIO / 2);
  logic [CW-1:0] cnt_r;

  // Free-running bit counter; slow clock is high for the first half word
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_r <= '0;
      o_slow_clk <= 1'b0;
      o_wrap <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + CW'(1);
      o_slow_clk <= (cnt_r == LAST) || (cnt_r < HALF - CW'(1));
      o_wrap <= (cnt_r == LAST - CW'(1));
    end
  end

  a_div_period: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_wrap |=> !o_wrap [*8])
    else $error("word boundary repeated too early");
endmodule

// ---- hdl/srx_rx_path_ctrl.sv ----
// Control around a recovered serial receive path: source choice,
// output gating and muting, PLL reference and oscillator floor hold.
// Assumes all pins synchronous to i_ref_clk, one serial bit per cycle.
//
// Summary of operation
// - Route one of two sources into recovery
// - CML input serves alone or as loopback
// - Separate enables for fast clock and data
// - Enables active low, default off at reset
// - Silence forces fast data output low
// - Reference choice makes PLL follow reference clock
// - Floor hold drives oscillator to minimum
// - Parallel silence feeds zeros into demultiplexer
// - Parallel silence leaves recovery outputs alone
// - Reference, hold and silence act independently
// - Outputs retimed data, fast and divided clock
// - Analog loss only after sustained low level
// - Lock within acquisition time of valid input
// - Parallel silence is active low, default normal
// - Reference choice active low, default follows data
//
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module srx_rx_path_ctrl #(
  parameter int LOCK_CYCLES = srx_pkg::LOCK_CYCLES,
  parameter int LOCK_CW = 20
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // Serial sources and reference
  input wire logic i_amp_serial_input,
  input wire logic i_cml_serial_input,
  input wire logic i_amp_level_low,
  input wire logic i_frequency_reference_clock,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wr_data,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rd_data,
  // High-speed outputs
  output logic o_fast_serial_data_out,
  output logic o_fast_data_oe,
  output logic o_fast_recovered_clock_out,
  output logic o_fast_clock_oe,
  // Parallel side
  output logic o_low_speed_clock_out,
  output logic [15:0] o_parallel_data,
  output logic o_parallel_valid,
  // Recovery status
  output logic o_analog_signal_loss,
  output logic o_transition_loss,
  output logic o_locked,
  output logic o_ref_in_use,
  output logic [7:0] o_osc_freq_code,
  // Interrupt
  output logic o_irq
);
  localparam logic [LOCK_CW-1:0] LOCK_LAST = LOCK_CW'(LOCK_CYCLES - 1);
  localparam int DW = srx_pkg::DEMUX_WIDTH;

  logic [srx_pkg::CTRL_W-1:0] ctrl_r;
  logic [srx_pkg::STAT_W-1:0] irq_stat_r, irq_mask_r, irq_stat_nxt, events;
  logic rx_bit_r, prev_bit_r, ref_prev_r, ref_edge_r;
  logic [DW-1:0] shift_r;
  logic [LOCK_CW-1:0] lock_cnt_r;
  logic lock_cnt_ok, locked_q, aloss_q, tloss_q;
  logic slow_clk, word_wrap;
  logic sel_cml, clk_on, data_on, data_sil, ref_sel, hold, par_sil;
  logic wr_ctrl, wr_stat, wr_mask;

  // Decoded controls, all active low with pull-up defaults
  assign sel_cml = !ctrl_r[srx_pkg::CB_SRC_SEL_N];
  assign clk_on = !ctrl_r[srx_pkg::CB_CLK_EN_N];
  assign data_on = !ctrl_r[srx_pkg::CB_DATA_EN_N];
  assign data_sil = !ctrl_r[srx_pkg::CB_DATA_SIL_N];
  assign ref_sel = !ctrl_r[srx_pkg::CB_REF_N];
  assign hold = !ctrl_r[srx_pkg::CB_HOLD_N];
  assign par_sil = !ctrl_r[srx_pkg::CB_PAR_SIL_N];
  assign wr_ctrl = i_wr && (i_addr == srx_pkg::OFS_CTRL);
  assign wr_stat = i_wr && (i_addr == srx_pkg::OFS_IRQ_STAT);
  assign wr_mask = i_wr && (i_addr == srx_pkg::OFS_IRQ_MASK);

  // Control register; each field is its own knob so any mix is legal
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= srx_pkg::CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= i_wr_data[srx_pkg::CTRL_W-1:0];
    end
  end

  // Source choice and retiming; loopback works whatever the amp carries
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_bit_r <= 1'b0;
      prev_bit_r <= 1'b0;
    end else begin
      rx_bit_r <= sel_cml ? i_cml_serial_input : i_amp_serial_input;
      prev_bit_r <= rx_bit_r;
    end
  end

  // Fast outputs; parallel silence has no say here
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_fast_serial_data_out <= 1'b0;
      o_fast_data_oe <= 1'b0;
      o_fast_recovered_clock_out <= 1'b0;
      o_fast_clock_oe <= 1'b0;
    end else begin
      o_fast_data_oe <= data_on;
      o_fast_clock_oe <= clk_on;
      o_fast_serial_data_out <= data_on && !data_sil && rx_bit_r;
      o_fast_recovered_clock_out <= clk_on && !o_fast_recovered_clock_out;
    end
  end

  // Word clock derived from the recovered bit clock
  srx_clk_div #(.RATIO(DW), .CW(4)) u_div (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .o_slow_clk(slow_clk),
    .o_wrap(word_wrap)
  );

  // Demultiplexer: first bit ends up in the top position
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      shift_r <= '0;
      o_parallel_data <= '0;
      o_parallel_valid <= 1'b0;
      o_low_speed_clock_out <= 1'b0;
    end else begin
      shift_r <= {shift_r[DW-2:0], rx_bit_r && !par_sil};
      o_parallel_valid <= word_wrap;
      o_low_speed_clock_out <= slow_clk;
      if (word_wrap) begin
        o_parallel_data <= shift_r;
      end
    end
  end

  // Loss qualification for low level and for missing transitions
  srx_loss_if aloss_if ();
  srx_loss_if tloss_if ();
  assign aloss_if.raw = i_amp_level_low && !sel_cml;
  assign tloss_if.raw = (rx_bit_r == prev_bit_r);
  assign aloss_q = aloss_if.qual;
  assign tloss_q = tloss_if.qual;
  srx_loss_filter #(.HOLD_CYCLES(srx_pkg::LOSS_CYCLES), .CW(8)) u_aloss (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .lif(aloss_if)
  );
  srx_loss_filter #(.HOLD_CYCLES(srx_pkg::LOSS_CYCLES), .CW(8)) u_tloss (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .lif(tloss_if)
  );

  // Reference edge seen; input is treated as a synchronous level
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ref_prev_r <= 1'b0;
      ref_edge_r <= 1'b0;
    end else begin
      ref_prev_r <= i_frequency_reference_clock;
      ref_edge_r <= i_frequency_reference_clock != ref_prev_r;
    end
  end

  // Oscillator code: hold wins, since it guards against upward drift
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_osc_freq_code <= srx_pkg::OSC_NOMINAL;
      o_ref_in_use <= 1'b0;
    end else begin
      o_ref_in_use <= ref_sel;
      if (hold) begin
        o_osc_freq_code <= srx_pkg::OSC_MIN;
      end else if (ref_sel || !(aloss_q || tloss_q)) begin
        o_osc_freq_code <= srx_pkg::OSC_NOMINAL;
      end else if (o_osc_freq_code != srx_pkg::OSC_MAX) begin
        o_osc_freq_code <= o_osc_freq_code + 8'h01;
      end
    end
  end

  // Acquisition counter; a valid input for the full time gives lock
  assign lock_cnt_ok = !hold && (ref_sel ? ref_edge_r : !(aloss_q || tloss_q));
  assign locked_q = o_locked;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lock_cnt_r <= '0;
      o_locked <= 1'b0;
    end else if (hold || (!ref_sel && (aloss_q || tloss_q))) begin
      lock_cnt_r <= '0;
      o_locked <= 1'b0;
    end else if (lock_cnt_r == LOCK_LAST) begin
      o_locked <= 1'b1;
    end else if (lock_cnt_ok || !ref_sel) begin
      lock_cnt_r <= lock_cnt_r + LOCK_CW'(1);
    end
  end

  // Loss flags to pins
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_analog_signal_loss <= 1'b0;
      o_transition_loss <= 1'b0;
    end else begin
      o_analog_signal_loss <= aloss_q;
      o_transition_loss <= tloss_q;
    end
  end

  // Sticky events; a new event beats a same-cycle clear
  always_comb begin
    events = '0;
    events[srx_pkg::SB_ALOSS] = aloss_q && !o_analog_signal_loss;
    events[srx_pkg::SB_TLOSS] = tloss_q && !o_transition_loss;
    events[srx_pkg::SB_LOCK] = (lock_cnt_r == LOCK_LAST) && !locked_q && !hold &&
      (ref_sel || !(aloss_q || tloss_q));
    events[srx_pkg::SB_UNLOCK] = locked_q && (hold || (!ref_sel && (aloss_q || tloss_q)));
    irq_stat_nxt = irq_stat_r;
    if (wr_stat) begin
      irq_stat_nxt = irq_stat_r & ~i_wr_data[srx_pkg::STAT_W-1:0];
    end
    irq_stat_nxt = irq_stat_nxt | events;
  end

  // Interrupt status, mask and output
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_stat_r <= srx_pkg::STAT_RST;
      irq_mask_r <= srx_pkg::STAT_RST;
      o_irq <= 1'b0;
    end else begin
      irq_stat_r <= irq_stat_nxt;
      if (wr_mask) begin
        irq_mask_r <= i_wr_data[srx_pkg::STAT_W-1:0];
      end
      o_irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_data <= '0;
    end else if (!i_rd) begin
      o_rd_data <= '0;
    end else begin
      case (i_addr)
        srx_pkg::OFS_CTRL: o_rd_data <= {25'h0, ctrl_r};
        srx_pkg::OFS_STATE: o_rd_data <= {20'h0, o_osc_freq_code, o_ref_in_use,
          o_locked, o_transition_loss, o_analog_signal_loss};
        srx_pkg::OFS_IRQ_STAT: o_rd_data <= {28'h0, irq_stat_r};
        srx_pkg::OFS_IRQ_MASK: o_rd_data <= {28'h0, irq_mask_r};
        srx_pkg::OFS_PARALLEL: o_rd_data <= {16'h0, o_parallel_data};
        default: o_rd_data <= '0;
      endcase
    end
  end

  // Checks; the sampled reset in the antecedent skips the edge that releases it
  a_source_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rst_n |=> rx_bit_r == $past(sel_cml ? i_cml_serial_input : i_amp_serial_input))
    else $error("wrong serial source routed");
  a_data_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !data_on |=> !o_fast_serial_data_out && !o_fast_data_oe)
    else $error("fast data driven while disabled");
  a_clock_enable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_on [*2] |-> o_fast_recovered_clock_out != $past(o_fast_recovered_clock_out))
    else $error("fast clock not toggling while enabled");
  a_data_silence: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    data_sil |=> !o_fast_serial_data_out)
    else $error("fast data not silenced");
  a_par_indep: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    par_sil && data_on && !data_sil |=> o_fast_serial_data_out == $past(rx_bit_r))
    else $error("parallel silence disturbed fast data");
  a_par_silence: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    par_sil |=> !shift_r[0])
    else $error("demultiplexer fed data while silenced");
  a_floor_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    hold |=> o_osc_freq_code == srx_pkg::OSC_MIN && !o_locked)
    else $error("oscillator not at floor during hold");
  a_ref_choice: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ref_sel && !hold |=> o_ref_in_use && o_osc_freq_code == srx_pkg::OSC_NOMINAL)
    else $error("reference not in use when chosen");
  a_lock_time: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_locked) |-> $past(lock_cnt_r) == LOCK_LAST)
    else $error("lock declared at wrong count");
  // Gating, capture and status timing, one cycle behind their causes; the lock event lands in the same cycle as lock
  a_cml_route: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sel_cml |=> rx_bit_r == $past(i_cml_serial_input))
    else $error("CML input not routed when chosen");
  a_clock_disable: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !clk_on |=> !o_fast_recovered_clock_out && !o_fast_clock_oe)
    else $error("fast clock driven while disabled");
  a_data_oe_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    data_on |=> o_fast_data_oe)
    else $error("fast data output not enabled");
  a_clock_oe_on: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    clk_on |=> o_fast_clock_oe)
    else $error("fast clock output not enabled");
  a_ref_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !ref_sel |=> !o_ref_in_use)
    else $error("reference in use while not chosen");
  a_hold_priority: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    hold && ref_sel |=> o_osc_freq_code == srx_pkg::OSC_MIN && o_ref_in_use)
    else $error("hold and reference choice interfered");
  a_par_capture: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    word_wrap |=> o_parallel_data == $past(shift_r))
    else $error("parallel word not captured at boundary");
  a_word_clock: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_parallel_valid |=> $rose(o_low_speed_clock_out))
    else $error("word clock out of step with valid");
  a_lock_event: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    $rose(o_locked) |-> irq_stat_r[srx_pkg::SB_LOCK])
    else $error("lock gained without status event");
  a_irq_level: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    1'b1 |=> o_irq == $past(|(irq_stat_r & irq_mask_r)))
    else $error("interrupt does not follow status and mask");
  a_read_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_rd |=> o_rd_data == 32'h0)
    else $error("read data shown without a read");
  a_irq_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    irq_stat_r[srx_pkg::SB_LOCK] && !wr_stat |=> irq_stat_r[srx_pkg::SB_LOCK])
    else $error("sticky status dropped without clear");

  c_loopback: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    sel_cml && data_on && o_fast_serial_data_out);
  c_all_knobs: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    ref_sel && hold && par_sil);
  c_lock: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_locked));
  c_irq: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) $rose(o_irq));
  c_floor: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    hold && o_osc_freq_code == srx_pkg::OSC_MIN);
endmodule

// ---- tb/srx_tia_model.sv ----
// Behavioural model of the optical receiver front end feeding the amplifier.
// Assumes one bit per cycle of the reference clock and a bench-driven dark flag.
`timescale 1ns/10ps
module srx_tia_model (
  // Clock
  input wire logic i_clk,
  // Light removed from the fibre
  input wire logic i_dark,
  // Serial bit and raw low-level flag
  output logic o_bit,
  output logic o_level_low
);
  // Known levels before the first edge
  initial begin
    o_bit = 1'b0;
    o_level_low = 1'b0;
  end
  // Alternating bits keep transitions alive; dark gives a flat line and low level
  always @(posedge i_clk) begin
    if (i_dark) begin
      o_bit <= 1'b0; // No transitions while dark
      o_level_low <= 1'b1;
    end else begin
      o_bit <= ~o_bit;
      o_level_low <= 1'b0;
    end
  end
endmodule

// ---- tb/tb_top.sv ----
// Self-checking bench for the serial receive path control block.
// Assumes the register port and all pins run on the one 100 MHz clock.
`timescale 1ns/10ps
module tb_top;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_cml_serial_input = 1'b0;
  logic i_frequency_reference_clock = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wr_data = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic dark = 1'b0;
  logic amp_bit, amp_low, fdo, fdoe, fco, fcoe, lsc, pvld, aloss, tloss, lock, refu, irq;
  logic [31:0] o_rd_data, rv;
  logic [15:0] pdat;
  logic [7:0] osc;
  logic [1:0] ha = 2'b00;
  logic [1:0] hc = 2'b00;
  logic prev;
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int n1, nv;

  // Short lock count keeps the run brief
  srx_rx_path_ctrl #(.LOCK_CYCLES(50), .LOCK_CW(20)) i_srx_rx_path_ctrl (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_amp_serial_input(amp_bit), .i_cml_serial_input(i_cml_serial_input),
    .i_amp_level_low(amp_low), .i_frequency_reference_clock(i_frequency_reference_clock),
    .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data),
    .o_fast_serial_data_out(fdo), .o_fast_data_oe(fdoe),
    .o_fast_recovered_clock_out(fco), .o_fast_clock_oe(fcoe),
    .o_low_speed_clock_out(lsc), .o_parallel_data(pdat), .o_parallel_valid(pvld),
    .o_analog_signal_loss(aloss), .o_transition_loss(tloss), .o_locked(lock),
    .o_ref_in_use(refu), .o_osc_freq_code(osc), .o_irq(irq));

  srx_tia_model i_srx_tia_model (.i_clk(i_ref_clk), .i_dark(dark), .o_bit(amp_bit),
    .o_level_low(amp_low));

  always #5 i_ref_clk = ~i_ref_clk;

  // CML source is the amplifier stream one cycle late, so a swap shows at once
  always @(posedge i_ref_clk) begin
    i_cml_serial_input <= amp_bit;
    i_frequency_reference_clock <= ~i_frequency_reference_clock;
    ha <= {ha[0], amp_bit};
    hc <= {hc[0], i_cml_serial_input};
  end

  // Hang guard, well above the fewer than one thousand cycles the tests need
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      errors = errors + 1;
      $display("ERROR timeout expected end seen hang");
      finish_test();
    end
  end

  task automatic finish_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk_reg(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_pin(input string what, input logic exp, input logic got);
    comparisons = comparisons + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("ERROR %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_wr_data <= d;
    i_wr <= 1'b1;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1 d = o_rd_data;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_ref_clk);
    #1;
  endtask

  // Follows the fast data pin bit by bit, two cycles behind the chosen source
  task automatic chk_path(input int n, input logic cml, input logic zero);
    repeat (n) begin
      cyc(1);
      chk_pin("fast_data", zero ? 1'b0 : (cml ? hc[1] : ha[1]), fdo);
    end
  endtask

  task automatic wait_lock();
    for (int k = 0; k < 100 && lock !== 1'b1; k++) cyc(1);
  endtask

  initial begin
    cyc(4);
    chk_pin("clk_oe_rst", 1'b0, fcoe);
    chk_reg("osc_rst", 32'h80, {24'h0, osc});
    repeat (4) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    rd(srx_pkg::OFS_CTRL, rv);
    chk_reg("ctrl_rst", 32'h7F, rv);
    rd(8'h20, rv);
    chk_reg("unmapped", 32'h0, rv);
    chk_path(20, 1'b0, 1'b1);
    wait_lock();
    chk_pin("locked", 1'b1, lock);
    $display("test reset and lock done");

    wr(srx_pkg::OFS_CTRL, 32'h79);
    cyc(2);
    chk_pin("data_oe", 1'b1, fdoe);
    chk_pin("clk_oe", 1'b1, fcoe);
    prev = fco;
    cyc(1);
    chk_pin("fast_clk", ~prev, fco);
    chk_path(40, 1'b0, 1'b0);
    // Any 16 cycles hold one word: eight high clock cycles and one valid
    n1 = 0;
    nv = 0;
    repeat (16) begin
      cyc(1);
      n1 = n1 + int'(lsc);
      nv = nv + int'(pvld);
    end
    chk_reg("slow_clk_high", 32'h8, n1);
    chk_reg("word_valid", 32'h1, nv);
    wr(srx_pkg::OFS_CTRL, 32'h7D);
    cyc(2);
    chk_pin("data_oe_off", 1'b0, fdoe);
    chk_pin("clk_oe_on", 1'b1, fcoe);
    chk_path(10, 1'b0, 1'b1);
    wr(srx_pkg::OFS_CTRL, 32'h78);
    cyc(2);
    chk_path(40, 1'b1, 1'b0);
    $display("test source and enables done");

    wr(srx_pkg::OFS_CTRL, 32'h71);
    cyc(2);
    chk_path(40, 1'b0, 1'b1);
    wr(srx_pkg::OFS_CTRL, 32'h79);
    cyc(40);
    chk_pin("par_alt", 1'b1, pdat === 16'hAAAA || pdat === 16'h5555);
    wr(srx_pkg::OFS_CTRL, 32'h39);
    cyc(40);
    chk_reg("par_sil", 32'h0, {16'h0, pdat});
    chk_path(40, 1'b0, 1'b0);
    chk_pin("lock_psil", 1'b1, lock);
    $display("test silences done");

    wr(srx_pkg::OFS_CTRL, 32'h69);
    cyc(3);
    chk_pin("ref_use", 1'b1, refu);
    wr(srx_pkg::OFS_CTRL, 32'h09);
    cyc(40);
    chk_reg("osc_floor", 32'h0, {24'h0, osc});
    chk_pin("ref_both", 1'b1, refu);
    chk_reg("par_both", 32'h0, {16'h0, pdat});
    rd(srx_pkg::OFS_STATE, rv);
    chk_reg("state_osc", 32'h0, {20'h0, rv[11:4]});
    wr(srx_pkg::OFS_CTRL, 32'h79);
    cyc(3);
    chk_pin("ref_off", 1'b0, refu);
    wait_lock();
    $display("test reference and hold done");

    wr(srx_pkg::OFS_IRQ_STAT, 32'hF);
    wr(srx_pkg::OFS_IRQ_MASK, 32'h1);
    cyc(3);
    chk_pin("irq_idle", 1'b0, irq);
    dark <= 1'b1;
    cyc(200);
    chk_pin("aloss_early", 1'b0, aloss);
    cyc(40);
    chk_pin("aloss_late", 1'b1, aloss);
    chk_pin("tloss_late", 1'b1, tloss);
    chk_pin("irq_set", 1'b1, irq);
    rd(srx_pkg::OFS_STATE, rv);
    chk_reg("state_aloss", 32'h1, {31'h0, rv[0]});
    // Both losses and the lost lock leave their sticky marks
    rd(srx_pkg::OFS_IRQ_STAT, rv);
    chk_reg("stat_events", 32'hB, rv);
    wr(srx_pkg::OFS_IRQ_MASK, 32'h0);
    cyc(3);
    chk_pin("irq_masked", 1'b0, irq);
    wr(srx_pkg::OFS_IRQ_MASK, 32'h1);
    cyc(3);
    chk_pin("irq_unmask", 1'b1, irq);
    wr(srx_pkg::OFS_IRQ_STAT, 32'h1);
    cyc(3);
    chk_pin("irq_clear", 1'b0, irq);
    rd(srx_pkg::OFS_IRQ_STAT, rv);
    chk_reg("stat_clr", 32'h0, {31'h0, rv[0]});
    dark <= 1'b0;
    cyc(10);
    chk_pin("aloss_gone", 1'b0, aloss);
    chk_pin("tloss_gone", 1'b0, tloss);
    wait_lock();
    chk_pin("relock", 1'b1, lock);
    $display("test loss and interrupt done");
    finish_test();
  end
endmodule
